// ---- rtl/pvo_pkg.sv ----
// Constants, register map and state type of the position/velocity output block
// What this block does
// [RULE1] One raw measurement every 1 ms scan tick
// [RULE2] Integration depth configurable, eight by default
// [RULE3] Output is mean of last valid samples
// [RULE4] Errors suppressed for error delay, default 50 ms
// [RULE5] Hold last valid value while delay runs
// [RULE6] After delay, output configured error values
// [RULE7] Position resolution selectable, host output only
// [RULE8] Offset and preset stored unscaled
// [RULE9] One unit setting: millimetres or 1/100 inch
// [RULE10] Enabled offset is added to position
// [RULE11] Preset event from input or bus captures preset
// [RULE12] Active preset overrides the offset
// [RULE13] Preset stores difference, added to later positions
// [RULE14] Velocity derived from successive positions
// [RULE15] Velocity resolution selectable, fieldbus output only; in inch mode the code ignores it and always divides by 254
// [RULE16] Velocity averaged over 2 to 128 ms
// [RULE17] Read quality reported as percentage
// [RULE18] Report read head to tape distance
// [RULE19] Tape distance only in service mode
package pvo_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned SCAN_PERIOD_US   = 1000;
  localparam int unsigned SCAN_CYCLES_DFLT = (CLK_HZ / 1_000_000) * SCAN_PERIOD_US;
  localparam int unsigned SMP_DEPTH        = 16;
  localparam int unsigned HIST_DEPTH       = 128;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_DEPTH   = 8'h04;
  localparam logic [7:0] OFF_ERRDLY  = 8'h08;
  localparam logic [7:0] OFF_OFFSET  = 8'h0C;
  localparam logic [7:0] OFF_PRESET  = 8'h10;
  localparam logic [7:0] OFF_ERRPOS  = 8'h14;
  localparam logic [7:0] OFF_ERRVEL  = 8'h18;
  localparam logic [7:0] OFF_POSDIV  = 8'h1C;
  localparam logic [7:0] OFF_VELDIV  = 8'h20;
  localparam logic [7:0] OFF_POSOUT  = 8'h24;
  localparam logic [7:0] OFF_VELOUT  = 8'h28;
  localparam logic [7:0] OFF_QUALITY = 8'h2C;
  localparam logic [7:0] OFF_DIST    = 8'h30;
  localparam logic [7:0] OFF_IRQSTS  = 8'h34;
  localparam logic [7:0] OFF_IRQMSK  = 8'h38;
  localparam logic [7:0] OFF_STATUS  = 8'h3C;
  // Control field positions
  localparam int unsigned CTRL_OFFSET_EN = 0;
  localparam int unsigned CTRL_PRESET_EN = 1;
  localparam int unsigned CTRL_INCH      = 2;
  localparam int unsigned CTRL_SERVICE   = 3;
  localparam int unsigned CTRL_PRESET_GO = 4;
  localparam int unsigned CTRL_POSRES_LO = 8;
  localparam int unsigned CTRL_VELRES_LO = 12;
  localparam int unsigned CTRL_VELAVG_LO = 16;
  // Interrupt bits
  localparam int unsigned IRQ_ERR     = 0;
  localparam int unsigned IRQ_PRESET  = 1;
  localparam int unsigned IRQ_RECOVER = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] DEPTH_RST  = 32'h0000_0008;
  localparam logic [31:0] ERRDLY_RST = 32'h0000_0032;
  localparam logic [31:0] ZERO_RST   = 32'h0000_0000;
  localparam logic [31:0] DIV_RST    = 32'h0000_0001;
  // Micrometres per parameter unit
  localparam logic signed [39:0] UM_PER_MM  = 40'sh00_0000_03E8;
  localparam logic signed [39:0] UM_PER_CIN = 40'sh00_0000_00FE;
  localparam logic [5:0]         DIV_STEPS  = 6'h30;
  typedef enum logic [2:0] {ST_IDLE, ST_MEAN, ST_LOAD, ST_POS, ST_VEL, ST_DONE} pvo_state_t;
endpackage : pvo_pkg

// ---- rtl/pvo_core.sv ----
// Position and velocity measurement processing with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module pvo_core #(
  parameter int unsigned SCAN_CYCLES = pvo_pkg::SCAN_CYCLES_DFLT
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic signed [39:0] meas_pos,
  input  wire logic               meas_valid,
  input  wire logic [6:0]         meas_quality,
  input  wire logic [15:0]        meas_dist,
  input  wire logic               preset_in,
  output logic                    scan_tick,
  output logic [31:0]             pos_out,
  output logic [31:0]             vel_out,
  output logic                    pos_ok,
  output logic [6:0]              quality_out,
  output logic [15:0]             dist_out,
  output logic                    irq
);
  logic [31:0]        tick_cnt_q;
  logic               tick_now;
  logic [7:0]         awaddr_q;
  logic [31:0]        wdata_q;
  logic [3:0]         wstrb_q;
  logic               wr_fire;
  logic               wr_hit;
  logic [31:0]        wr_val;
  logic [31:0]        rd_mux;
  logic               rd_hit;
  logic [31:0]        ctrl_q, depth_q, errdly_q, offset_q, preset_q;
  logic [31:0]        errpos_q, errvel_q, posdiv_q, veldiv_q;
  logic [2:0]         irq_sts_q, irq_msk_q, irq_set;
  logic signed [39:0] smp_q [pvo_pkg::SMP_DEPTH];
  logic [3:0]         smp_wr_q;
  logic [4:0]         smp_fill_q, depth_eff, smp_n;
  logic signed [43:0] smp_sum;
  logic signed [39:0] hist_q [pvo_pkg::HIST_DEPTH];
  logic [6:0]         hist_wr_q;
  logic signed [39:0] mean_q, preset_diff_q, unit_mul, corr, pos_corr, vel_diff, vel_um;
  logic               preset_set_q, preset_in_q, preset_evt;
  logic [15:0]        err_cnt_q;
  logic               err_act_q, cur_valid_q;
  logic [2:0]         avg_sel;
  logic [7:0]         vel_n;
  pvo_pkg::pvo_state_t st_q;
  logic [47:0]        div_rem_q, div_quo_q, rem_sh;
  logic [23:0]        div_den_q, div_den, pos_den, vel_den;
  logic [5:0]         div_cnt_q;
  logic               div_neg_q, div_load, div_done, rem_ge;
  logic signed [47:0] div_num, div_res;

  // Byte-lane merge of a write into a register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[8*b +: 8] = d[8*b +: 8];
    end
    return r;
  endfunction : merge

  // Scan tick every millisecond
  assign tick_now = (tick_cnt_q == 32'(SCAN_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0;
      scan_tick  <= 1'b0;
    end else begin
      tick_cnt_q <= tick_now ? 32'h0 : tick_cnt_q + 32'h1;  // [RULE1]
      scan_tick  <= tick_now;
    end
  end

  // AXI write channel: address and data taken in either order, response after both
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      awaddr_q      <= 8'h0;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;  // Unmapped or read-only gives SLVERR
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable address decode
  always_comb begin
    case (awaddr_q)
      pvo_pkg::OFF_CTRL, pvo_pkg::OFF_DEPTH, pvo_pkg::OFF_ERRDLY, pvo_pkg::OFF_OFFSET,
      pvo_pkg::OFF_PRESET, pvo_pkg::OFF_ERRPOS, pvo_pkg::OFF_ERRVEL, pvo_pkg::OFF_POSDIV,
      pvo_pkg::OFF_VELDIV, pvo_pkg::OFF_IRQSTS, pvo_pkg::OFF_IRQMSK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Configuration registers, kept as written except control bit 4 (preset go), which is always cleared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= pvo_pkg::CTRL_RST;
      depth_q   <= pvo_pkg::DEPTH_RST;   // [RULE2]
      errdly_q  <= pvo_pkg::ERRDLY_RST;  // [RULE4]
      offset_q  <= pvo_pkg::ZERO_RST;
      preset_q  <= pvo_pkg::ZERO_RST;
      errpos_q  <= pvo_pkg::ZERO_RST;
      errvel_q  <= pvo_pkg::ZERO_RST;
      posdiv_q  <= pvo_pkg::DIV_RST;
      veldiv_q  <= pvo_pkg::DIV_RST;
      irq_msk_q <= 3'h0;
    end else if (wr_fire) begin
      case (awaddr_q)
        pvo_pkg::OFF_CTRL:   ctrl_q   <= merge(ctrl_q, wdata_q, wstrb_q) & ~32'h0000_0010;
        pvo_pkg::OFF_DEPTH:  depth_q  <= merge(depth_q, wdata_q, wstrb_q);
        pvo_pkg::OFF_ERRDLY: errdly_q <= merge(errdly_q, wdata_q, wstrb_q);
        pvo_pkg::OFF_OFFSET: offset_q <= merge(offset_q, wdata_q, wstrb_q);  // [RULE8]
        pvo_pkg::OFF_PRESET: preset_q <= merge(preset_q, wdata_q, wstrb_q);  // [RULE8]
        pvo_pkg::OFF_ERRPOS: errpos_q <= merge(errpos_q, wdata_q, wstrb_q);
        pvo_pkg::OFF_ERRVEL: errvel_q <= merge(errvel_q, wdata_q, wstrb_q);
        pvo_pkg::OFF_POSDIV: posdiv_q <= merge(posdiv_q, wdata_q, wstrb_q);
        pvo_pkg::OFF_VELDIV: veldiv_q <= merge(veldiv_q, wdata_q, wstrb_q);
        pvo_pkg::OFF_IRQMSK: irq_msk_q <= wstrb_q[0] ? wdata_q[2:0] : irq_msk_q;
        default: ;
      endcase
    end
  end

  // Interrupt status: hardware set wins over a write-one clear
  assign wr_val = (wr_fire && awaddr_q == pvo_pkg::OFF_IRQSTS && wstrb_q[0]) ? wdata_q : 32'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_q <= 3'h0;
      irq       <= 1'b0;
    end else begin
      irq_sts_q <= (irq_sts_q & ~wr_val[2:0]) | irq_set;
      irq       <= |(irq_sts_q & irq_msk_q);
    end
  end

  // AXI read channel with registered data
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      pvo_pkg::OFF_CTRL:    rd_mux = ctrl_q;
      pvo_pkg::OFF_DEPTH:   rd_mux = depth_q;
      pvo_pkg::OFF_ERRDLY:  rd_mux = errdly_q;
      pvo_pkg::OFF_OFFSET:  rd_mux = offset_q;
      pvo_pkg::OFF_PRESET:  rd_mux = preset_q;
      pvo_pkg::OFF_ERRPOS:  rd_mux = errpos_q;
      pvo_pkg::OFF_ERRVEL:  rd_mux = errvel_q;
      pvo_pkg::OFF_POSDIV:  rd_mux = posdiv_q;
      pvo_pkg::OFF_VELDIV:  rd_mux = veldiv_q;
      pvo_pkg::OFF_POSOUT:  rd_mux = pos_out;
      pvo_pkg::OFF_VELOUT:  rd_mux = vel_out;
      pvo_pkg::OFF_QUALITY: rd_mux = {25'h0, quality_out};  // [RULE17]
      pvo_pkg::OFF_DIST:    rd_mux = {16'h0, dist_out};
      pvo_pkg::OFF_IRQSTS:  rd_mux = {29'h0, irq_sts_q};
      pvo_pkg::OFF_IRQMSK:  rd_mux = {29'h0, irq_msk_q};
      pvo_pkg::OFF_STATUS:  rd_mux = {28'h0, cur_valid_q, preset_set_q, err_cnt_q != 16'h0, err_act_q};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Sample ring of valid raw measurements, one entry per slot
  for (genvar g = 0; g < pvo_pkg::SMP_DEPTH; g++) begin : g_smp
    always_ff @(posedge aclk) begin
      if (tick_now && meas_valid && smp_wr_q == 4'(g)) smp_q[g] <= meas_pos;  // [RULE1]
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smp_wr_q   <= 4'h0;
      smp_fill_q <= 5'h0;
    end else if (tick_now && meas_valid) begin
      smp_wr_q   <= smp_wr_q + 4'h1;
      smp_fill_q <= (smp_fill_q == 5'h10) ? smp_fill_q : smp_fill_q + 5'h1;
    end
  end

  // Sum of the last depth valid samples
  assign depth_eff = (depth_q == 32'h0) ? 5'h1 : (depth_q > 32'h10) ? 5'h10 : depth_q[4:0];  // [RULE2]
  assign smp_n     = (smp_fill_q < depth_eff) ? smp_fill_q : depth_eff;
  always_comb begin
    smp_sum = 44'sh0;
    for (int i = 0; i < pvo_pkg::SMP_DEPTH; i++) begin
      if (5'(i) < smp_n) smp_sum = smp_sum + 44'(smp_q[4'(smp_wr_q - 4'(i) - 4'h1)]);  // [RULE3]
    end
  end

  // Error delay and scan validity tracking
  assign irq_set[pvo_pkg::IRQ_ERR]     = tick_now && !meas_valid && !err_act_q && (32'(err_cnt_q) + 32'h1 >= errdly_q);
  assign irq_set[pvo_pkg::IRQ_RECOVER] = tick_now && meas_valid && err_act_q;
  assign irq_set[pvo_pkg::IRQ_PRESET]  = preset_evt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_cnt_q   <= 16'h0;
      err_act_q   <= 1'b0;
      cur_valid_q <= 1'b0;
      quality_out <= 7'h0;
      dist_out    <= 16'h0;
    end else if (tick_now) begin
      cur_valid_q <= meas_valid;
      quality_out <= meas_quality;  // [RULE17]
      dist_out    <= ctrl_q[pvo_pkg::CTRL_SERVICE] ? meas_dist : 16'h0;  // [RULE18] [RULE19]
      if (meas_valid) begin
        err_cnt_q <= 16'h0;
        err_act_q <= 1'b0;
      end else begin
        err_cnt_q <= (err_cnt_q == 16'hFFFF) ? err_cnt_q : err_cnt_q + 16'h1;  // [RULE4]
        if (irq_set[pvo_pkg::IRQ_ERR]) err_act_q <= 1'b1;
      end
    end
  end

  // Unit and correction selection
  assign unit_mul = ctrl_q[pvo_pkg::CTRL_INCH] ? pvo_pkg::UM_PER_CIN : pvo_pkg::UM_PER_MM;  // [RULE9]
  always_comb begin
    if (ctrl_q[pvo_pkg::CTRL_PRESET_EN] && preset_set_q) corr = preset_diff_q;  // [RULE12] [RULE13]
    else if (ctrl_q[pvo_pkg::CTRL_OFFSET_EN]) corr = 40'($signed(offset_q)) * unit_mul;  // [RULE10]
    else corr = 40'sh0;
  end
  assign pos_corr = mean_q + corr;

  // Preset event from switching input edge or control write
  assign preset_evt = (preset_in && !preset_in_q) ||
                      (wr_fire && awaddr_q == pvo_pkg::OFF_CTRL && wstrb_q[0] && wdata_q[pvo_pkg::CTRL_PRESET_GO]);  // [RULE11]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preset_in_q   <= 1'b0;
      preset_set_q  <= 1'b0;
      preset_diff_q <= 40'sh0;
    end else begin
      preset_in_q <= preset_in;
      if (preset_evt) begin
        preset_set_q  <= 1'b1;
        preset_diff_q <= 40'($signed(preset_q)) * unit_mul - mean_q;  // [RULE11] [RULE13]
      end
    end
  end

  // Velocity over the averaging window from position history
  assign avg_sel  = (ctrl_q[18:16] > 3'h6) ? 3'h6 : ctrl_q[18:16];
  assign vel_n    = 8'h02 << avg_sel;  // [RULE16]
  assign vel_diff = mean_q - hist_q[7'(hist_wr_q - vel_n[6:0])];  // [RULE14]
  assign vel_um   = vel_diff >>> (avg_sel + 3'h1);  // [RULE16]
  always_ff @(posedge aclk) begin
    if (st_q == pvo_pkg::ST_DONE && cur_valid_q) hist_q[hist_wr_q] <= mean_q;
  end

  // Output divisors
  always_comb begin
    case (ctrl_q[10:8])
      3'h0: pos_den = 24'h00_0001;
      3'h1: pos_den = 24'h00_000A;
      3'h2: pos_den = 24'h00_0064;
      3'h3: pos_den = 24'h00_03E8;
      3'h4: pos_den = 24'h00_2710;
      default: pos_den = (posdiv_q[23:0] == 24'h0) ? 24'h00_0001 : posdiv_q[23:0];
    endcase
    if (ctrl_q[pvo_pkg::CTRL_INCH] && ctrl_q[10:8] < 3'h5) pos_den = pvo_pkg::UM_PER_CIN[23:0];  // [RULE9]
    case (ctrl_q[14:12])
      3'h0: vel_den = 24'h00_0001;
      3'h1: vel_den = 24'h00_000A;
      3'h2: vel_den = 24'h00_0064;
      3'h3: vel_den = 24'h00_03E8;
      default: vel_den = (veldiv_q[23:0] == 24'h0) ? 24'h00_0001 : veldiv_q[23:0];
    endcase
  end

  // Divider operand selection per stage
  always_comb begin
    div_load = 1'b0;
    div_num  = 48'sh0;
    div_den  = 24'h00_0001;
    case (st_q)
      pvo_pkg::ST_IDLE: begin
        div_load = scan_tick;
        div_num  = 48'(smp_sum);
        div_den  = (smp_n == 5'h0) ? 24'h00_0001 : {19'h0, smp_n};  // [RULE3]
      end
      pvo_pkg::ST_LOAD: begin
        div_load = 1'b1;
        div_num  = 48'(pos_corr);
        div_den  = pos_den;  // [RULE7]
      end
      pvo_pkg::ST_POS: begin
        div_load = div_done;
        div_num  = ctrl_q[pvo_pkg::CTRL_INCH] ? 48'(vel_um) * 48'sh3E8 : 48'(vel_um);
        div_den  = ctrl_q[pvo_pkg::CTRL_INCH] ? pvo_pkg::UM_PER_CIN[23:0] : vel_den;  // [RULE15]
      end
      default: ;
    endcase
  end

  // Restoring divider step
  assign rem_sh   = {div_rem_q[46:0], div_quo_q[47]};
  assign rem_ge   = rem_sh >= {24'h0, div_den_q};
  assign div_done = (div_cnt_q == 6'h0);
  assign div_res  = div_neg_q ? -$signed(div_quo_q) : $signed(div_quo_q);

  // Per-scan processing sequence and divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= pvo_pkg::ST_IDLE;
      div_rem_q <= 48'h0;
      div_quo_q <= 48'h0;
      div_den_q <= 24'h00_0001;
      div_cnt_q <= 6'h0;
      div_neg_q <= 1'b0;
      mean_q    <= 40'sh0;
      hist_wr_q <= 7'h0;
      pos_out   <= 32'h0;
      vel_out   <= 32'h0;
      pos_ok    <= 1'b0;
    end else begin
      if (div_load) begin
        div_rem_q <= 48'h0;
        div_quo_q <= div_num[47] ? 48'(-div_num) : 48'(div_num);
        div_den_q <= div_den;
        div_neg_q <= div_num[47];
        div_cnt_q <= pvo_pkg::DIV_STEPS;
      end else if (!div_done) begin
        div_rem_q <= rem_ge ? rem_sh - {24'h0, div_den_q} : rem_sh;
        div_quo_q <= {div_quo_q[46:0], rem_ge};
        div_cnt_q <= div_cnt_q - 6'h1;
      end
      case (st_q)
        pvo_pkg::ST_IDLE: if (scan_tick) st_q <= pvo_pkg::ST_MEAN;
        pvo_pkg::ST_MEAN: begin
          if (div_done) begin
            mean_q <= div_res[39:0];  // [RULE3]
            st_q   <= pvo_pkg::ST_LOAD;
          end
        end
        pvo_pkg::ST_LOAD: st_q <= pvo_pkg::ST_POS;
        pvo_pkg::ST_POS: begin
          if (div_done) begin
            pos_out <= cur_valid_q ? div_res[31:0] : pos_out;  // [RULE7]
            st_q    <= pvo_pkg::ST_VEL;
          end
        end
        pvo_pkg::ST_VEL: begin
          if (div_done) begin
            vel_out <= cur_valid_q ? div_res[31:0] : vel_out;  // [RULE15]
            st_q    <= pvo_pkg::ST_DONE;
          end
        end
        pvo_pkg::ST_DONE: begin
          st_q <= pvo_pkg::ST_IDLE;
          if (cur_valid_q) begin
            pos_ok    <= 1'b1;
            hist_wr_q <= hist_wr_q + 7'h1;
          end else if (err_act_q) begin
            pos_out <= errpos_q;  // [RULE6]
            vel_out <= errvel_q;  // [RULE6]
            pos_ok  <= 1'b0;
          end  // Otherwise last valid values are held [RULE5]
        end
        default: st_q <= pvo_pkg::ST_IDLE;
      endcase
    end
  end
endmodule : pvo_core
`default_nettype wire

// ---- bench/pvo_core_sva.sv ----
// Assertions on bus handshakes and scan timing
`timescale 1ns/1ps
`default_nettype none
module pvo_core_sva #(
  parameter int unsigned SCAN_CYCLES = 400
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        scan_tick,
  input wire logic [31:0] pos_out,
  input wire logic [31:0] vel_out,
  input wire logic        pos_ok,
  input wire logic        irq
);
  logic [31:0] gap_q;
  logic        seen_q;
  // Cycles since last tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b0;
    end else if (scan_tick) begin
      gap_q  <= 32'h0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Scan timing
  chk_tick_period: assert property (scan_tick && seen_q |-> gap_q == SCAN_CYCLES - 1)
    else $error("tick period");
  chk_tick_pulse: assert property (scan_tick |=> !scan_tick)
    else $error("tick too long");
  chk_pos_window: assert property ($changed(pos_out) |-> seen_q && gap_q > 0 && gap_q < 300)
    else $error("pos change late");
  chk_vel_window: assert property ($changed(vel_out) |-> seen_q && gap_q > 0 && gap_q < 300)
    else $error("vel change late");
  // Bus handshakes
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("b late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("b dropped");
  chk_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("w while busy");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("r late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("r dropped");
  // Scenarios
  cov_tick: cover property (scan_tick && seen_q);
  cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cov_err: cover property ($fell(pos_ok));
  cov_irq: cover property ($rose(irq));
endmodule : pvo_core_sva
bind pvo_core pvo_core_sva #(.SCAN_CYCLES(SCAN_CYCLES)) chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .scan_tick, .pos_out, .vel_out, .pos_ok, .irq);
`default_nettype wire

// ---- bench/pvo_meas_model.sv ----
// Measurement source model
`timescale 1ns/1ps
`default_nettype none
module pvo_meas_model (
  input  wire logic               aclk,
  input  wire logic               scan_tick,
  input  wire logic               load,
  input  wire logic signed [39:0] base,
  input  wire logic signed [39:0] step,
  input  wire logic               valid_in,
  output logic signed [39:0]      meas_pos,
  output logic                    meas_valid
);
  logic signed [39:0] pos_q;
  // Step after each tick; invalid reads look scrambled
  always_ff @(posedge aclk) begin
    meas_valid <= valid_in;
    if (load) begin
      pos_q <= base;
    end else if (scan_tick) begin
      pos_q <= pos_q + step;
    end
  end
  assign meas_pos = meas_valid ? pos_q : ~pos_q;
endmodule : pvo_meas_model
`default_nettype wire

// ---- bench/position_velocity_output_processing_test.sv ----
// Bench for the position and velocity block
`timescale 1ns/1ps
`default_nettype none
module position_velocity_output_processing_test;
  logic        aclk, aresetn, awv, wv, bry, arv, rry, ld, vin, pin;
  logic        mv, awr, wrd, bv, arr, rv, tick, pok, irq;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, p, t, rdat, po, vo;
  logic [3:0]  ws;
  logic [1:0]  rr, br, rsp;
  logic [6:0]  q, qo;
  logic [15:0] ds, dso;
  logic [39:0] bs, st, mp;
  int          num_errors = 0, checked = 0, cyc = 0, seed = 32'h2d1e;
  int          dv[5] = '{1, 10, 100, 1000, 10000};
  logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h38};
  logic [31:0] rx[6] = '{32'h0, 32'h8, 32'h32, 32'h0, 32'h1, 32'h0};
  pvo_core #(.SCAN_CYCLES(400)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rsp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .meas_pos(mp), .meas_valid(mv), .meas_quality(q), .meas_dist(ds), .preset_in(pin), .scan_tick(tick),
    .pos_out(po), .vel_out(vo), .pos_ok(pok), .quality_out(qo), .dist_out(dso), .irq(irq));
  pvo_meas_model src_u (.aclk(aclk), .scan_tick(tick), .load(ld), .base(bs), .step(st), .valid_in(vin),
    .meas_pos(mp), .meas_valid(mv));
  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic check_value(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check_value
  // Bus write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd  <= d;
    ws  <= 4'hF;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (awv || wv);
    do @(posedge aclk); while (!bv);
    rr = br;
    bry <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    rd = rdat;
    rr = rsp;
    rry <= 1'b0;
    @(posedge aclk);
  endtask : rdr
  task automatic scans(input int n);
    repeat (n) begin
      do @(posedge aclk); while (!tick);
    end
    repeat (250) @(posedge aclk);
  endtask : scans
  task automatic load_pos(input logic [39:0] v);
    bs <= v;
    ld <= 1'b1;
    @(posedge aclk);
    ld <= 1'b0;
  endtask : load_pos
  function automatic logic [31:0] exp_div(input logic [39:0] v, input int d);
    return 32'(v / 40'(d));
  endfunction : exp_div
  // Main sequence
  initial begin
    {aresetn, awv, wv, bry, arv, rry, pin, awa, ara, wd, ws, bs, st, q, ds} = '0;
    ld  = 1'b1;
    vin = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    ld      <= 1'b0;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rdr(ra[i]);
      check_value(rd, rx[i]);
    end
    rdr(8'h40);
    check_value(32'(rr), 32'h2);
    wr(pvo_pkg::OFF_POSOUT, 32'h1);
    check_value(32'(rr), 32'h2);
    p = 32'($random(seed)) & 32'h00FF_FFFF;
    t = $random(seed);
    q  <= t[6:0] % 7'h65;
    ds <= t[31:16];
    load_pos(40'(p));
    scans(10);
    for (int r = 0; r < 5; r++) begin
      wr(pvo_pkg::OFF_CTRL, 32'(r) << 8);
      scans(2);
      check_value(po, exp_div(40'(p), dv[r]));
    end
    check_value(32'(qo), 32'(t[6:0] % 7'h65));
    check_value(32'(dso), 32'h0);
    wr(pvo_pkg::OFF_CTRL, 32'h8);
    scans(1);
    check_value(32'(dso), 32'(t[31:16]));
    // Offset, inch
    wr(pvo_pkg::OFF_OFFSET, 32'h5);
    wr(pvo_pkg::OFF_CTRL, 32'h301);
    scans(2);
    check_value(po, exp_div(40'(p) + 40'h1388, 1000));
    rdr(pvo_pkg::OFF_OFFSET);
    check_value(rd, 32'h5);
    wr(pvo_pkg::OFF_CTRL, 32'h4);
    scans(2);
    check_value(po, exp_div(40'(p), 254));
    // Preset by input
    wr(pvo_pkg::OFF_PRESET, 32'h64);
    wr(pvo_pkg::OFF_IRQMSK, 32'h7);
    wr(pvo_pkg::OFF_CTRL, 32'h3);
    pin <= 1'b1;
    repeat (5) @(posedge aclk);
    pin <= 1'b0;
    check_value(32'(irq), 32'h1);
    scans(2);
    check_value(po, 32'h186A0);
    load_pos(40'(p) + 40'h309);
    scans(10);
    check_value(po, 32'h186A0 + 32'h309);
    wr(pvo_pkg::OFF_IRQSTS, 32'h2);
    repeat (2) @(posedge aclk);
    check_value(32'(irq), 32'h0);
    // Preset by write
    wr(pvo_pkg::OFF_IRQMSK, 32'h0);
    wr(pvo_pkg::OFF_CTRL, 32'h13);
    scans(2);
    check_value(po, 32'h186A0);
    check_value(32'(irq), 32'h0);
    rdr(pvo_pkg::OFF_IRQSTS);
    check_value(rd & 32'h2, 32'h2);
    // Read errors
    wr(pvo_pkg::OFF_CTRL, 32'h0);
    wr(pvo_pkg::OFF_ERRDLY, 32'h3);
    wr(pvo_pkg::OFF_ERRPOS, 32'h1234);
    wr(pvo_pkg::OFF_ERRVEL, 32'h56);
    wr(pvo_pkg::OFF_IRQMSK, 32'h1);
    scans(2);
    vin <= 1'b0;
    scans(2);
    check_value(po, p + 32'h309);
    check_value(32'(pok), 32'h1);
    scans(3);
    check_value(po, 32'h1234);
    check_value(vo, 32'h56);
    check_value(32'(pok), 32'h0);
    check_value(32'(irq), 32'h1);
    vin <= 1'b1;
    scans(1);
    check_value(32'(pok), 32'h1);
    // Velocity ramp
    st <= 40'h32;
    scans(14);
    check_value(vo, 32'h32);
    wr(pvo_pkg::OFF_CTRL, 32'h2_1000);
    scans(20);
    check_value(vo, 32'h5);
    complete_run();
  end
endmodule : position_velocity_output_processing_test
`default_nettype wire
